/* File: src/gdc_consts.vh */
// gdc_consts.vh: command encodings, field positions, reset values and timing figures
// assumes: included by the command/bank control module; definitions only
`ifndef GDC_CONSTS_VH
`define GDC_CONSTS_VH
// command encodings {cs_n, ras_n, cas_n, we_n} with chip select low
`define GDC_CMD_NOP      4'h7
`define GDC_CMD_ACTIVE   4'h3
`define GDC_CMD_READ     4'h5
`define GDC_CMD_WRITE    4'h4
`define GDC_CMD_PRECH    4'h2
`define GDC_CMD_REFRESH  4'h1
`define GDC_CMD_MODE     4'h0
// strobe-only encoding {ras_n, cas_n, we_n} for the read snoop
`define GDC_SNOOP_READ   3'h5
// field positions
`define GDC_AP_BIT       8
`define GDC_COL_LO_MSB   7
`define GDC_COL_HI_BIT   9
`define GDC_BANK_BIT0    0
`define GDC_BANK_BIT1    1
// mode load targets {bank_select_bit1, bank_select_bit0}
`define GDC_MR_MAIN      2'h0
`define GDC_MR_EXT       2'h1
// extended mode register: data termination field and its dual-load code
`define GDC_EMR_DT_LSB   2
`define GDC_EMR_DT_MSB   3
`define GDC_DT_DUAL      2'h1
// reset values
`define GDC_MR_RST       12'h000
`define GDC_EMR_RST      12'h000
`define GDC_ROW_RST      12'h000
// timing figures in ns, clock period in ps; burst length, read latency in clocks and counter width
`define GDC_CLK_PS       20000
`define GDC_MRD_NS       10
`define GDC_RP_NS        20
`define GDC_RAS_NS       40
`define GDC_XSNR_NS      200
`define GDC_BURST_LEN    4
`define GDC_READ_LAT     7
`define GDC_CNT_W        16
`endif

/* File: src/gdc_cmd_bank_ctrl.v */
// gdc_cmd_bank_ctrl.v: command decode, bank state, auto precharge, refresh, self refresh
// and data termination control of a graphics double-data-rate memory device.
// assumes: command pins already synchronous to ref_clk; the controller keeps its timings.
//
// Functional notes
// R1: decode command from four strobes
// R2: mode load bank bits pick register
// R3: refresh with clock enable low self-refreshes
// R4: chip select high accepts no command
// R5: no-operation changes nothing at all
// R6: mode load takes op-code, waits delay
// R7: activate opens addressed row in bank
// R8: controller precharges before other row
// R9: column from low bits, bit8 auto precharge
// R10: masked byte writes are suppressed
// R11: precharge bit8 high closes all banks
// R12: controller waits precharge before activate
// R13: auto precharge respects minimum active time
// R14: controller idles bank during auto precharge
// R15: refresh row comes from internal counter
// R16: controller refreshes within interval limits
// R17: controller self-refreshes only when idle
// R18: self refresh disables loop and termination
// R19: controller waits after self refresh exit
// R20: controller keeps power-down minimums
// R21: snooped read disables data termination
// R22: command termination always stays enabled
// R23: reset release samples clock enable rank
// R24: controller honours row to column delay
// R25: controller spaces activates by row times
// R26: one command per enabled clock edge
`timescale 1ns/1ps
`include "gdc_consts.vh"
module gdc_cmd_bank_ctrl #(
   parameter BANKS = 8,
   parameter BANK_W = 3,
   parameter ADDR_W = 12,
   parameter BYTES = 4
) (
   // clock, reset, clock enable
   input wire ref_clk,
   input wire nrst,
   input wire clk_en,
   // command and address pins
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [BANK_W-1:0] bank_sel,
   input wire [ADDR_W-1:0] addr,
   // write data byte masks, level per beat
   input wire write_beat,
   input wire [BYTES-1:0] write_byte_mask,
   // bank state
   output reg [BANKS-1:0] bank_open_reg,
   output wire [BANKS*ADDR_W-1:0] open_rows,
   // column access
   output reg col_valid_reg,
   output reg col_is_write_reg,
   output reg [BANK_W-1:0] col_bank_reg,
   output reg [8:0] col_addr_reg,
   output reg col_auto_pre_reg,
   output reg [BYTES-1:0] byte_write_en_reg,
   // mode registers
   output reg [ADDR_W-1:0] mode_reg,
   output reg [ADDR_W-1:0] ext_mode_reg,
   output reg mode_busy_reg,
   // refresh
   output reg refresh_pulse_reg,
   output reg [ADDR_W-1:0] refresh_row_reg,
   output reg self_refresh_reg,
   output reg dll_enable_reg,
   output reg dll_reset_reg,
   // termination
   output reg dual_rank_reg,
   output reg addr_half_term_reg,
   output wire ca_term_en,
   output reg dq_term_en_reg
);
   // derived cycle counts: least times round up
   localparam [`GDC_CNT_W-1:0] MRD_CYC = (`GDC_MRD_NS * 1000 + `GDC_CLK_PS - 1) / `GDC_CLK_PS;
   localparam [`GDC_CNT_W-1:0] RP_CYC = (`GDC_RP_NS * 1000 + `GDC_CLK_PS - 1) / `GDC_CLK_PS;
   localparam [`GDC_CNT_W-1:0] RAS_CYC = (`GDC_RAS_NS * 1000 + `GDC_CLK_PS - 1) / `GDC_CLK_PS;
   localparam [`GDC_CNT_W-1:0] XSNR_CYC =
      (`GDC_XSNR_NS * 1000 + `GDC_CLK_PS - 1) / `GDC_CLK_PS;
   localparam [`GDC_CNT_W-1:0] BURST_CYC = `GDC_BURST_LEN / 2;
   localparam [`GDC_CNT_W-1:0] DT_DELAY = `GDC_READ_LAT - 1;
   localparam [`GDC_CNT_W-1:0] DT_LEN = `GDC_BURST_LEN / 2 + 2;
   localparam [`GDC_CNT_W-1:0] CNT_ONE = 1;

   wire [3:0] cmd;
   wire en_cyc;
   wire is_act;
   wire is_rd;
   wire is_wr;
   wire is_pre;
   wire is_ref;
   wire is_mode;
   wire snoop_rd;
   wire dual_load;
   reg rst_seen_reg;
   reg [ADDR_W-1:0] row_reg [0:BANKS-1];
   reg [`GDC_CNT_W-1:0] mode_cnt_reg;
   reg [`GDC_CNT_W-1:0] xsnr_cnt_reg;
   reg [`GDC_CNT_W-1:0] dt_delay_reg;
   reg [`GDC_CNT_W-1:0] dt_len_reg;
   reg dt_pending_reg;

   // one decode per enabled edge; cs_n high yields no command (see R26) (see R4)
   assign en_cyc = clk_en && !self_refresh_reg;
   assign cmd = {cs_n, ras_n, cas_n, we_n};                         // see R1
   assign is_act = en_cyc && cke && cmd == `GDC_CMD_ACTIVE;
   assign is_rd = en_cyc && cke && cmd == `GDC_CMD_READ;
   assign is_wr = en_cyc && cke && cmd == `GDC_CMD_WRITE;
   assign is_pre = en_cyc && cke && cmd == `GDC_CMD_PRECH;
   assign is_ref = en_cyc && cmd == `GDC_CMD_REFRESH;
   assign is_mode = en_cyc && cke && cmd == `GDC_CMD_MODE;
   // a no-operation matches none of the above, so no state moves (see R5)
   // read snoop ignores chip select so both ranks see reads to either (see R21)
   assign snoop_rd = en_cyc && cke && {ras_n, cas_n, we_n} == `GDC_SNOOP_READ;
   assign dual_load = ext_mode_reg[`GDC_EMR_DT_MSB:`GDC_EMR_DT_LSB] == `GDC_DT_DUAL;
   // command and address termination never switches off (see R22)
   assign ca_term_en = 1'b1;

   // per-bank row store and open flag with auto precharge timer
   genvar gi;
   generate
      for (gi = 0; gi < BANKS; gi = gi + 1) begin : g_bank
         reg [`GDC_CNT_W-1:0] ras_cnt_reg;
         reg [`GDC_CNT_W-1:0] ap_cnt_reg;
         reg ap_pend_reg;
         wire sel;
         assign sel = bank_sel == gi[BANK_W-1:0];
         assign open_rows[gi*ADDR_W +: ADDR_W] = row_reg[gi];
         always @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               bank_open_reg[gi] <= 1'b0;
               row_reg[gi] <= `GDC_ROW_RST;
               ras_cnt_reg <= {`GDC_CNT_W{1'b0}};
               ap_cnt_reg <= {`GDC_CNT_W{1'b0}};
               ap_pend_reg <= 1'b0;
            end else if (clk_en) begin
               if (ras_cnt_reg != {`GDC_CNT_W{1'b0}})
                  ras_cnt_reg <= ras_cnt_reg - CNT_ONE;
               if (ap_cnt_reg != {`GDC_CNT_W{1'b0}})
                  ap_cnt_reg <= ap_cnt_reg - CNT_ONE;
               if (is_act && sel) begin
                  // open the addressed row; stays open until precharged (see R7)
                  bank_open_reg[gi] <= 1'b1;
                  row_reg[gi] <= addr;
                  ras_cnt_reg <= RAS_CYC;
                  ap_pend_reg <= 1'b0;
               end else if (is_pre && (addr[`GDC_AP_BIT] || sel)) begin
                  // a precharge to an idle bank is harmless and simply repeats the close
                  bank_open_reg[gi] <= 1'b0;                      // see R11
                  ap_pend_reg <= 1'b0;
               end else if ((is_rd || is_wr) && sel && addr[`GDC_AP_BIT]) begin
                  // auto precharge is armed only for this access (see R13)
                  ap_pend_reg <= 1'b1;
                  ap_cnt_reg <= BURST_CYC;
               end else if (ap_pend_reg && ap_cnt_reg == {`GDC_CNT_W{1'b0}} &&
                            ras_cnt_reg == {`GDC_CNT_W{1'b0}}) begin
                  // close at burst end, but never before minimum active time (see R13)
                  bank_open_reg[gi] <= 1'b0;
                  ap_pend_reg <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // column access capture: bank, column bits 7:0 and 9, auto precharge flag
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         col_valid_reg <= 1'b0;
         col_is_write_reg <= 1'b0;
         col_bank_reg <= {BANK_W{1'b0}};
         col_addr_reg <= 9'h000;
         col_auto_pre_reg <= 1'b0;
      end else if (clk_en) begin
         // a read or write to a closed bank is still reported; the controller owns that
         col_valid_reg <= is_rd || is_wr;
         if (is_rd || is_wr) begin
            col_is_write_reg <= is_wr;
            col_bank_reg <= bank_sel;                                // see R9
            col_addr_reg <= {addr[`GDC_COL_HI_BIT], addr[`GDC_COL_LO_MSB:0]};
            col_auto_pre_reg <= addr[`GDC_AP_BIT];
         end
      end
   end

   // byte enables: a mask high leaves that byte untouched (see R10)
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         byte_write_en_reg <= {BYTES{1'b0}};
      else if (clk_en)
         byte_write_en_reg <= write_beat ? ~write_byte_mask : {BYTES{1'b0}};
   end

   // mode loads pick a target by the two low bank bits; others ignored
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= `GDC_MR_RST;
         ext_mode_reg <= `GDC_EMR_RST;
         mode_busy_reg <= 1'b0;
         mode_cnt_reg <= {`GDC_CNT_W{1'b0}};
      end else if (clk_en) begin
         if (is_mode) begin
            case ({bank_sel[`GDC_BANK_BIT1], bank_sel[`GDC_BANK_BIT0]})  // see R2
               `GDC_MR_MAIN: mode_reg <= addr;                         // see R6
               `GDC_MR_EXT: ext_mode_reg <= addr;
               default: ;
            endcase
            mode_busy_reg <= 1'b1;
            mode_cnt_reg <= MRD_CYC;
         end else if (mode_cnt_reg != {`GDC_CNT_W{1'b0}}) begin
            mode_cnt_reg <= mode_cnt_reg - CNT_ONE;
            mode_busy_reg <= mode_cnt_reg != CNT_ONE;
         end else begin
            mode_busy_reg <= 1'b0;
         end
      end
   end

   // refresh: counter row on auto refresh; cke low enters self refresh (see R3)
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         refresh_pulse_reg <= 1'b0;
         refresh_row_reg <= `GDC_ROW_RST;
         self_refresh_reg <= 1'b0;
         dll_enable_reg <= 1'b1;
         dll_reset_reg <= 1'b0;
         xsnr_cnt_reg <= {`GDC_CNT_W{1'b0}};
      end else if (clk_en) begin
         refresh_pulse_reg <= 1'b0;
         dll_reset_reg <= 1'b0;
         if (xsnr_cnt_reg != {`GDC_CNT_W{1'b0}})
            xsnr_cnt_reg <= xsnr_cnt_reg - CNT_ONE;
         if (is_ref && cke) begin
            // address pins are ignored; the internal counter walks the rows (see R15)
            refresh_pulse_reg <= 1'b1;
            refresh_row_reg <= refresh_row_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
         end else if (is_ref && !cke) begin
            // from here on only a rise of cke is looked at
            self_refresh_reg <= 1'b1;
            dll_enable_reg <= 1'b0;                                   // see R18
         end else if (self_refresh_reg && cke) begin
            // exit: loop back on and reset, termination restored (see R18)
            self_refresh_reg <= 1'b0;
            dll_enable_reg <= 1'b1;
            dll_reset_reg <= 1'b1;
            xsnr_cnt_reg <= XSNR_CYC;
         end
      end
   end

   // data termination: off from read latency minus one for half burst plus two
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dq_term_en_reg <= 1'b1;
         dt_pending_reg <= 1'b0;
         dt_delay_reg <= {`GDC_CNT_W{1'b0}};
         dt_len_reg <= {`GDC_CNT_W{1'b0}};
      end else if (clk_en) begin
         if (snoop_rd && dual_load) begin                              // see R21
            dt_pending_reg <= 1'b1;
            dt_delay_reg <= DT_DELAY - CNT_ONE;
         end else if (dt_pending_reg) begin
            if (dt_delay_reg == {`GDC_CNT_W{1'b0}}) begin
               dt_pending_reg <= 1'b0;
               dt_len_reg <= DT_LEN;
            end else begin
               dt_delay_reg <= dt_delay_reg - CNT_ONE;
            end
         end
         if (dt_len_reg != {`GDC_CNT_W{1'b0}} && !(dt_pending_reg &&
             dt_delay_reg == {`GDC_CNT_W{1'b0}}))
            dt_len_reg <= dt_len_reg - CNT_ONE;
         // self refresh forces termination off (see R18)
         // the exit edge itself (cke high) turns it back on together with the loop
         dq_term_en_reg <= !(self_refresh_reg && !cke) && !(is_ref && !cke) &&
            !(dt_pending_reg && dt_delay_reg == {`GDC_CNT_W{1'b0}}) &&
            !(dt_len_reg > CNT_ONE);
      end
   end

   // rank strap: sample cke on the first clock after reset release (see R23)
   // ignores clk_en on purpose: a frozen first edge would let cke move on
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_seen_reg <= 1'b0;
         dual_rank_reg <= 1'b0;
         addr_half_term_reg <= 1'b0;
      end else begin
         if (!rst_seen_reg) begin
            rst_seen_reg <= 1'b1;
            dual_rank_reg <= cke;
            addr_half_term_reg <= !cke;
         end
      end
   end
endmodule

/* File: testbench/gdc_cmd_bank_ctrl_properties.sv */
// checker: command decode, bank state, refresh and termination of the control block
// assumes: bound to gdc_cmd_bank_ctrl, one clock ref_clk, async low reset nrst
`timescale 1ns/1ps
`include "gdc_consts.vh"
module gdc_props #(
   parameter BANKS = 8,
   parameter BANK_W = 3,
   parameter ADDR_W = 12,
   parameter BYTES = 4
) (
   // clock, reset and clock enable
   input wire ref_clk,
   input wire nrst,
   input wire clk_en,
   // command and address pins
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [BANK_W-1:0] bank_sel,
   input wire [ADDR_W-1:0] addr,
   // write beat and byte masks
   input wire write_beat,
   input wire [BYTES-1:0] write_byte_mask,
   // bank and column state
   input wire [BANKS-1:0] bank_open_reg,
   input wire [BANKS*ADDR_W-1:0] open_rows,
   input wire col_valid_reg,
   input wire [8:0] col_addr_reg,
   input wire [BYTES-1:0] byte_write_en_reg,
   // mode, refresh and termination state
   input wire [ADDR_W-1:0] mode_reg,
   input wire [ADDR_W-1:0] ext_mode_reg,
   input wire refresh_pulse_reg,
   input wire [ADDR_W-1:0] refresh_row_reg,
   input wire self_refresh_reg,
   input wire dll_enable_reg,
   input wire dll_reset_reg,
   input wire ca_term_en,
   input wire dq_term_en_reg
);
   // a command counts only when the clock is enabled and the device is awake
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire en = clk_en && !self_refresh_reg;
   wire go = en && cke;
   wire snoop = go && {ras_n, cas_n, we_n} == `GDC_SNOOP_READ &&
      ext_mode_reg[`GDC_EMR_DT_MSB:`GDC_EMR_DT_LSB] == `GDC_DT_DUAL;
   reg [ADDR_W-1:0] addr_q, row_q;
   reg [BANK_W-1:0] bank_q;
   // one-cycle copies so a consequent can name its cause
   always @(posedge ref_clk) begin
      addr_q <= addr;
      bank_q <= bank_sel;
      row_q <= refresh_row_reg;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_act; go && cmd == `GDC_CMD_ACTIVE |=> bank_open_reg[bank_q] &&
      open_rows[bank_q*ADDR_W +: ADDR_W] == addr_q; endproperty
   a_act: assert property (p_act) else $error("row not opened");
   // a frozen clock keeps old pulses, so only enabled edges count
   property p_desel; clk_en && cs_n |=> !col_valid_reg && !refresh_pulse_reg &&
      $stable(mode_reg);
   endproperty
   a_desel: assert property (p_desel) else $error("deselect acted");
   property p_nop; go && cmd == `GDC_CMD_NOP |=> !col_valid_reg && $stable(ext_mode_reg);
   endproperty
   a_nop: assert property (p_nop) else $error("nop acted");
   property p_col; go && (cmd == `GDC_CMD_READ || cmd == `GDC_CMD_WRITE) |=>
      col_valid_reg && col_addr_reg == {addr_q[9], addr_q[7:0]}; endproperty
   a_col: assert property (p_col) else $error("column wrong");
   property p_pall; go && cmd == `GDC_CMD_PRECH && addr[8] |=> bank_open_reg == '0;
   endproperty
   a_pall: assert property (p_pall) else $error("banks left open");
   property p_mask; en && write_beat |=> byte_write_en_reg == ~$past(write_byte_mask);
   endproperty
   a_mask: assert property (p_mask) else $error("mask ignored");
   property p_aref; go && cmd == `GDC_CMD_REFRESH |=> refresh_pulse_reg &&
      refresh_row_reg == row_q + 1'b1; endproperty
   a_aref: assert property (p_aref) else $error("refresh row wrong");
   property p_sref; en && !cke && cmd == `GDC_CMD_REFRESH |=>
      self_refresh_reg && !dll_enable_reg && !dq_term_en_reg; endproperty
   a_sref: assert property (p_sref) else $error("self refresh entry");
   property p_exit; clk_en && self_refresh_reg && cke |=> !self_refresh_reg &&
      dll_enable_reg && dll_reset_reg && dq_term_en_reg; endproperty
   a_exit: assert property (p_exit) else $error("self refresh exit");
   property p_snoop; snoop |-> ##7 !dq_term_en_reg [*4] ##1 dq_term_en_reg; endproperty
   a_snoop: assert property (p_snoop) else $error("term not off");
   property p_ca; ca_term_en; endproperty
   a_ca: assert property (p_ca) else $error("ca term off");
   c_snoop: cover property (snoop);
   c_exit: cover property (self_refresh_reg && cke);
   c_ap: cover property ($fell(bank_open_reg[5]));
endmodule
bind gdc_cmd_bank_ctrl gdc_props #(.BANKS(BANKS), .BANK_W(BANK_W), .ADDR_W(ADDR_W),
   .BYTES(BYTES)) u_props (.ref_clk, .nrst, .clk_en, .cke, .cs_n, .ras_n, .cas_n, .we_n,
   .write_beat, .bank_sel, .addr, .mode_reg, .ext_mode_reg, .refresh_row_reg,
   .write_byte_mask, .byte_write_en_reg, .bank_open_reg, .open_rows, .col_addr_reg,
   .col_valid_reg, .refresh_pulse_reg, .self_refresh_reg, .dll_enable_reg,
   .dll_reset_reg, .ca_term_en, .dq_term_en_reg);

/* File: testbench/gdc_host.sv */
// host controller model: drives command, address and write mask pins
// assumes: every task returns just after the edge that took its request
`timescale 1ns/1ps
module gdc_host (
   // clock
   input wire ref_clk,
   // command, address and mask pins
   output reg cke,
   output reg cs_n,
   output reg ras_n,
   output reg cas_n,
   output reg we_n,
   output reg write_beat,
   output reg [2:0] bank_sel,
   output reg [11:0] addr,
   output reg [3:0] write_byte_mask
);
   // idle: deselected, clock enable low so the rank strap reads single
   initial begin
      {cke, cs_n, ras_n, cas_n, we_n, write_beat} = 6'h1e;
      bank_sel = 3'h0;
      addr = 12'h000;
      write_byte_mask = 4'h0;
   end
   // one command then a deselect; the gap also covers the one-cycle delays
   task cmd(input [3:0] c, input [2:0] b, input [11:0] a, input k);
      begin
         @(posedge ref_clk);
         #1;
         {cs_n, ras_n, cas_n, we_n} = c;
         bank_sel = b;
         addr = a;
         cke = k;
         @(posedge ref_clk);
         #1;
         {cs_n, ras_n, cas_n, we_n} = 4'hf;
         addr = ~addr; // stale values never look valid
         bank_sel = ~bank_sel;
      end
   endtask
   // one write beat with its byte masks
   task beat(input [3:0] m);
      begin
         @(posedge ref_clk);
         #1;
         write_beat = 1'b1;
         write_byte_mask = m;
         @(posedge ref_clk);
         #1;
         write_beat = 1'b0;
         write_byte_mask = ~m;
      end
   endtask
endmodule

/* File: testbench/test_gdc_cmd_bank_ctrl.sv */
// bench: command sequences through the host model, checked against expected state
// assumes: gdc_host drives the pins, checker bound to the design
`timescale 1ns/1ps
`include "gdc_consts.vh"
module test_gdc_cmd_bank_ctrl;
   reg ref_clk = 1'b0;
   reg nrst = 1'b0;
   reg clk_en = 1'b1;
   integer error_cnt = 0, total_checks = 0, cyc = 0, i, lows;
   wire cke, cs_n, ras_n, cas_n, we_n, write_beat, col_valid_reg, col_is_write_reg;
   wire col_auto_pre_reg, mode_busy_reg, refresh_pulse_reg, self_refresh_reg;
   wire dll_enable_reg, dll_reset_reg, dual_rank_reg, addr_half_term_reg;
   wire ca_term_en, dq_term_en_reg;
   wire [2:0] bank_sel, col_bank_reg;
   wire [3:0] write_byte_mask, byte_write_en_reg;
   wire [7:0] bank_open_reg;
   wire [8:0] col_addr_reg;
   wire [11:0] addr, mode_reg, ext_mode_reg, refresh_row_reg;
   wire [95:0] open_rows;
   always #10 ref_clk = ~ref_clk;
   gdc_host host (.ref_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .write_beat, .bank_sel,
      .addr, .write_byte_mask);
   gdc_cmd_bank_ctrl dut (.ref_clk, .nrst, .clk_en, .cke, .cs_n, .ras_n, .cas_n, .we_n,
      .bank_sel, .addr, .write_beat, .write_byte_mask, .bank_open_reg, .open_rows,
      .col_valid_reg, .col_is_write_reg, .col_bank_reg, .col_addr_reg, .col_auto_pre_reg,
      .byte_write_en_reg, .mode_reg, .ext_mode_reg, .mode_busy_reg, .refresh_pulse_reg,
      .refresh_row_reg, .self_refresh_reg, .dll_enable_reg, .dll_reset_reg,
      .dual_rank_reg, .addr_half_term_reg, .ca_term_en, .dq_term_en_reg);
   task chk(input [95:0] seen, input [95:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   // reset for 8 cycles with the strap level k on clock enable
   task do_reset(input k);
      begin
         nrst = 1'b0;
         host.cmd(4'hf, 3'h0, 12'h000, k);
         repeat (6) @(posedge ref_clk);
         #1;
         nrst = 1'b1;
      end
   endtask
   // a hang ends the run; the sequence needs about 110 cycles
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         end_sim;
      end
   end
   initial begin
      do_reset(1'b0);
      host.cmd(`GDC_CMD_NOP, 3'h0, 12'hfff, 1'b1);
      chk({dual_rank_reg, addr_half_term_reg, ca_term_en, dll_enable_reg, dq_term_en_reg},
         5'h0f);
      chk({bank_open_reg, mode_reg, ext_mode_reg}, 32'h0);
      host.cmd(`GDC_CMD_MODE, 3'h0, 12'h123, 1'b1);
      chk({mode_busy_reg, mode_reg}, 13'h1123);
      host.cmd(`GDC_CMD_MODE, 3'h1, 12'h004, 1'b1);
      host.cmd(`GDC_CMD_MODE, 3'h2, 12'hfff, 1'b1);
      chk({mode_reg, ext_mode_reg}, 24'h123004);
      done("mode");
      host.cmd(4'hb, 3'h0, 12'h0aa, 1'b1);
      chk(bank_open_reg, 8'h00);
      // each bank opened once, so no precharge is owed first
      for (i = 0; i < 8; i = i + 1) begin
         host.cmd(`GDC_CMD_ACTIVE, i[2:0], {9'h080, i[2:0]}, 1'b1);
         chk(open_rows[i*12 +: 12], {9'h080, i[2:0]});
      end
      chk(bank_open_reg, 8'hff);
      host.cmd(`GDC_CMD_READ, 3'h3, 12'h2a5, 1'b1);
      chk({col_valid_reg, col_is_write_reg, col_auto_pre_reg, col_bank_reg, col_addr_reg},
         {3'b100, 3'h3, 9'h1a5});
      host.cmd(`GDC_CMD_WRITE, 3'h5, 12'h1ff, 1'b1);
      chk({col_valid_reg, col_is_write_reg, col_auto_pre_reg, col_bank_reg, col_addr_reg},
         {3'b111, 3'h5, 9'h0ff});
      repeat (3) @(posedge ref_clk);
      #1;
      chk(bank_open_reg, 8'hdf);
      host.beat(4'ha);
      chk(byte_write_en_reg, 4'h5);
      host.beat(4'hf);
      chk(byte_write_en_reg, 4'h0);
      host.cmd(`GDC_CMD_PRECH, 3'h3, 12'h000, 1'b1);
      chk(bank_open_reg, 8'hd7);
      host.cmd(`GDC_CMD_PRECH, 3'h6, 12'h100, 1'b1);
      chk(bank_open_reg, 8'h00);
      // power-down: cke low, no-operation then deselect, 40 ns before anything else
      host.cmd(`GDC_CMD_NOP, 3'h0, 12'h000, 1'b0);
      host.cmd(`GDC_CMD_ACTIVE, 3'h2, 12'h002, 1'b0);
      chk(bank_open_reg, 8'h00);
      done("banks");
      // refreshes back to back, far inside the interval limit
      for (i = 1; i < 3; i = i + 1) begin
         host.cmd(`GDC_CMD_REFRESH, 3'h7, 12'hfff, 1'b1);
         chk({refresh_pulse_reg, refresh_row_reg}, {1'b1, i[11:0]});
      end
      host.cmd(4'hd, 3'h0, 12'h000, 1'b1);
      chk(col_valid_reg, 1'b0);
      lows = 0;
      repeat (12) begin
         @(posedge ref_clk);
         #1;
         lows = lows + !dq_term_en_reg;
      end
      chk(lows, `GDC_BURST_LEN / 2 + 2);
      done("refresh");
      // all banks idle before entry
      host.cmd(`GDC_CMD_REFRESH, 3'h0, 12'h000, 1'b0);
      chk({self_refresh_reg, dll_enable_reg, dq_term_en_reg}, 3'b100);
      host.cmd(`GDC_CMD_ACTIVE, 3'h1, 12'h001, 1'b0);
      chk(bank_open_reg, 8'h00);
      host.cmd(4'hf, 3'h0, 12'h000, 1'b1);
      chk({self_refresh_reg, dll_enable_reg, dll_reset_reg, dq_term_en_reg}, 4'h7);
      // no-operations for the exit time, no read afterwards
      repeat (10) host.cmd(`GDC_CMD_NOP, 3'h0, 12'h000, 1'b1);
      clk_en = 1'b0;
      host.cmd(`GDC_CMD_ACTIVE, 3'h1, 12'h001, 1'b1);
      chk(bank_open_reg, 8'h00);
      clk_en = 1'b1;
      host.cmd(`GDC_CMD_ACTIVE, 3'h1, 12'h001, 1'b1);
      chk(bank_open_reg, 8'h02);
      done("selfref");
      do_reset(1'b1);
      host.cmd(`GDC_CMD_NOP, 3'h0, 12'h000, 1'b1);
      chk({dual_rank_reg, addr_half_term_reg, bank_open_reg}, 10'h200);
      done("rank");
      end_sim;
   end
endmodule
